// ==== dsr_diag_regs.sv ====
`timescale 1ns/100ps
module dsr_diag_regs (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// read request decoded from the serial command byte
	input wire logic rd_strobe,
	input wire logic rd_clear,
	input wire logic [5:0] rd_addr,
	// read answer
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_hit,
	// watchdog events
	input wire logic wd_trigger_ok,
	input wire logic wd_trigger_missed,
	input wire logic [1:0] watchdog_window_phase,
	// supply and thermal events
	input wire logic regulator_low_prewarn,
	input wire logic main_regulator_output_below_2v,
	input wire logic thermal_shutdown_level2_restart_event,
	input wire logic thermal_shutdown_level2,
	input wire logic thermal_shutdown_level1,
	input wire logic thermal_warning_flag,
	input wire logic short_at_startup,
	// battery standby request
	output logic force_standby
);
	import dsr_pkg::*;

	logic [3:0] watchdog_miss_count; // not cleared by reads
	logic forced_standby_by_watchdog; // sticky
	logic forced_standby_by_thermal_or_short; // sticky
	logic [1:0] phase_q; // registered window phase
	logic regulator_low_prewarn_q; // sticky
	logic [2:0] regulator_restart_count; // sticky counter
	logic regulator_collapse_flag; // sticky
	logic thermal_shutdown_level2_q;
	logic thermal_shutdown_level1_q;
	logic tw_q;
	logic collapse_pulse; // from the filter
	logic [3:0] next_miss;
	logic next_fwd;
	logic next_fts;
	logic next_prewarn;
	logic [2:0] next_restart;
	logic next_collapse;
	logic next_thermal_shutdown_level2;
	logic next_thermal_shutdown_level1;
	logic next_tw;
	logic [7:0] next_rd_data;
	logic next_rd_valid;
	logic next_rd_hit;
	logic next_force;
	logic clr_wd; // read-and-clear aimed at the watchdog byte
	logic clr_sup; // read-and-clear aimed at the supply byte
	logic [7:0] wd_byte;
	logic [7:0] sup_byte;

	// collapse filter qualifies the raw comparator
	dsr_collapse_filter #(
		.CYCLES(COLLAPSE_CYCLES)
	) u_filter (
		.mclk(mclk),
		.rstn(rstn),
		.below_2v(main_regulator_output_below_2v),
		.collapse_pulse(collapse_pulse)
	);

	// sticky flag update: set has priority over the clear
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction : sticky

	// assemble the two data bytes from live state
	always_comb begin
		wd_byte = RESET_BYTE;
		wd_byte[WD_MISS_LSB +: 4] = watchdog_miss_count;
		wd_byte[WD_FORCED_WD_BIT] = forced_standby_by_watchdog;
		wd_byte[WD_FORCED_TS_BIT] = forced_standby_by_thermal_or_short;
		wd_byte[WD_PHASE_LSB +: 2] = phase_q;
		sup_byte = RESET_BYTE;
		sup_byte[SUP_PREWARN_BIT] = regulator_low_prewarn_q;
		sup_byte[SUP_RESTART_LSB +: 3] = regulator_restart_count;
		sup_byte[SUP_COLLAPSE_BIT] = regulator_collapse_flag;
		sup_byte[SUP_THERMAL_SHUTDOWN_LEVEL2_BIT] = thermal_shutdown_level2_q;
		sup_byte[SUP_THERMAL_SHUTDOWN_LEVEL1_BIT] = thermal_shutdown_level1_q;
		sup_byte[SUP_TW_BIT] = tw_q;
	end

	// address decode for clearing; a clear only takes the addressed byte
	always_comb begin
		clr_wd = rd_strobe && rd_clear && (rd_addr == ADDR_WATCHDOG_DIAGNOSIS);
		clr_sup = rd_strobe && rd_clear && (rd_addr == ADDR_SUPPLY_THERMAL_DIAGNOSIS);
	end

	// next state of the watchdog group
	always_comb begin
		next_miss = watchdog_miss_count;
		// a good trigger wins over a miss in the same cycle
		if (wd_trigger_ok) begin
			next_miss = 4'h0;
		end else if (wd_trigger_missed && watchdog_miss_count != WD_MISS_LIMIT) begin
			next_miss = watchdog_miss_count + 4'h1;
		end
		// the read-and-clear deliberately leaves the count alone
		next_fwd = sticky(forced_standby_by_watchdog,
			next_miss == WD_MISS_LIMIT && watchdog_miss_count != WD_MISS_LIMIT, clr_wd);
		// the restart limit is judged on the count after any supply clear, so a clear
		// that restarts the count at one cannot also claim a forced standby
		next_fts = sticky(forced_standby_by_thermal_or_short,
			short_at_startup || (next_restart == RESTART_LIMIT &&
			regulator_restart_count != RESTART_LIMIT),
			clr_wd);
	end

	// next state of the supply group; the watchdog group reads next_restart from here
	always_comb begin
		next_prewarn = sticky(regulator_low_prewarn_q, regulator_low_prewarn, clr_sup);
		next_collapse = sticky(regulator_collapse_flag, collapse_pulse, clr_sup);
		next_thermal_shutdown_level2 = sticky(thermal_shutdown_level2_q, thermal_shutdown_level2, clr_sup);
		next_thermal_shutdown_level1 = sticky(thermal_shutdown_level1_q, thermal_shutdown_level1, clr_sup);
		next_tw = sticky(tw_q, thermal_warning_flag, clr_sup);
		next_restart = regulator_restart_count;
		// an event in the clear cycle becomes a count of one, not lost
		if (clr_sup) begin
			next_restart = thermal_shutdown_level2_restart_event ? 3'h1 : 3'h0;
		end else if (thermal_shutdown_level2_restart_event && regulator_restart_count != RESTART_LIMIT) begin
			next_restart = regulator_restart_count + 3'h1;
		end
	end

	// read answer and standby request
	always_comb begin
		next_rd_valid = rd_strobe;
		next_rd_hit = 1'b0;
		next_rd_data = RESET_BYTE;
		if (rd_strobe) begin
			unique case (rd_addr)
				ADDR_WATCHDOG_DIAGNOSIS: begin
					next_rd_data = wd_byte;
					next_rd_hit = 1'b1;
				end
				ADDR_SUPPLY_THERMAL_DIAGNOSIS: begin
					next_rd_data = sup_byte;
					next_rd_hit = 1'b1;
				end
				default: begin
					// other addresses belong to other banks; answer zero
					next_rd_data = RESET_BYTE;
				end
			endcase
		end
		// hold the request while either forcing condition stands
		next_force = (next_miss == WD_MISS_LIMIT) ||
			(next_restart == RESTART_LIMIT) || next_fts;
	end

	// register every group
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			watchdog_miss_count <= 4'h0;
			forced_standby_by_watchdog <= 1'b0;
			forced_standby_by_thermal_or_short <= 1'b0;
			phase_q <= PHASE_EARLY;
			regulator_low_prewarn_q <= 1'b0;
			regulator_restart_count <= 3'h0;
			regulator_collapse_flag <= 1'b0;
			thermal_shutdown_level2_q <= 1'b0;
			thermal_shutdown_level1_q <= 1'b0;
			tw_q <= 1'b0;
			rd_data <= RESET_BYTE;
			rd_valid <= 1'b0;
			rd_hit <= 1'b0;
			force_standby <= 1'b0;
		end else begin
			watchdog_miss_count <= next_miss;
			forced_standby_by_watchdog <= next_fwd;
			forced_standby_by_thermal_or_short <= next_fts;
			phase_q <= watchdog_window_phase;
			regulator_low_prewarn_q <= next_prewarn;
			regulator_restart_count <= next_restart;
			regulator_collapse_flag <= next_collapse;
			thermal_shutdown_level2_q <= next_thermal_shutdown_level2;
			thermal_shutdown_level1_q <= next_thermal_shutdown_level1;
			tw_q <= next_tw;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
			rd_hit <= next_rd_hit;
			force_standby <= next_force;
		end
	end
endmodule : dsr_diag_regs

// ==== dsr_pkg.sv ====
package dsr_pkg;
	// register addresses carried in the low six bits of the command byte
	localparam logic [5:0] ADDR_WATCHDOG_DIAGNOSIS = 6'h13;
	localparam logic [5:0] ADDR_SUPPLY_THERMAL_DIAGNOSIS = 6'h14;
	// watchdog register fields
	localparam int WD_MISS_LSB = 4;
	localparam int WD_FORCED_WD_BIT = 3;
	localparam int WD_FORCED_TS_BIT = 2;
	localparam int WD_PHASE_LSB = 0;
	// supply register fields
	localparam int SUP_PREWARN_BIT = 7;
	localparam int SUP_RESTART_LSB = 4;
	localparam int SUP_COLLAPSE_BIT = 3;
	localparam int SUP_THERMAL_SHUTDOWN_LEVEL2_BIT = 2;
	localparam int SUP_THERMAL_SHUTDOWN_LEVEL1_BIT = 1;
	localparam int SUP_TW_BIT = 0;
	// limits
	localparam logic [3:0] WD_MISS_LIMIT = 4'hF;
	localparam logic [2:0] RESTART_LIMIT = 3'h7;
	// window phase encodings
	localparam logic [1:0] PHASE_EARLY = 2'h0;
	localparam logic [1:0] PHASE_MID = 2'h1;
	localparam logic [1:0] PHASE_LATE = 2'h3;
	// collapse filter: 2 us at 20 MHz, least time rounds up
	localparam int CLK_HZ = 20_000_000;
	localparam int COLLAPSE_NS = 2000;
	localparam int COLLAPSE_CYCLES = (COLLAPSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : dsr_pkg

// ==== dsr_collapse_filter.sv ====
`timescale 1ns/100ps
// flags a regulator collapse once the low level has lasted longer than the filter time
module dsr_collapse_filter #(
	parameter int CYCLES = dsr_pkg::COLLAPSE_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// comparator level and qualified event
	input wire logic below_2v,
	output logic collapse_pulse
);
	import dsr_pkg::*;
	initial begin
		if (CYCLES < 1 || CYCLES > 65535) $error("collapse filter length out of range");
	end
	logic [15:0] cnt; // cycles the level has stayed low
	logic [15:0] next_cnt;
	logic next_pulse;
	// count while low; pulse once when the time is exceeded
	always_comb begin
		next_cnt = cnt;
		next_pulse = 1'b0;
		if (!below_2v) begin
			next_cnt = 16'h0000;
		end else if (cnt <= 16'(CYCLES)) begin
			next_cnt = cnt + 16'h0001;
			// strictly longer than the time, so fire one past the count
			next_pulse = (cnt == 16'(CYCLES));
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 16'h0000;
			collapse_pulse <= 1'b0;
		end else begin
			cnt <= next_cnt;
			collapse_pulse <= next_pulse;
		end
	end
endmodule : dsr_collapse_filter

// ==== dsr_host.sv ====
`timescale 1ns/100ps
// host side: issues decoded reads, one byte per request
module dsr_host (
	// clock
	input wire logic mclk,
	// decoded command toward the block
	output logic rd_strobe,
	output logic rd_clear,
	output logic [5:0] rd_addr
);
	// idle until the first request
	initial begin
		rd_strobe = 1'b0;
		rd_clear = 1'b0;
		rd_addr = 6'h00;
	end
	// caller stands just after a rising edge; last releases the lines
	task rd(input logic [5:0] a, input logic c, input logic last);
		rd_strobe = 1'b1;
		rd_addr = a;
		rd_clear = c;
		@(posedge mclk);
		#1;
		// a released address shows the inverse, not the old value
		if (last) begin
			rd_strobe = 1'b0;
			rd_clear = 1'b0;
			rd_addr = ~a;
		end
	endtask : rd
endmodule : dsr_host

// ==== dsr_diag_regs_sva.sv ====
`timescale 1ns/100ps
module dsr_diag_regs_sva
	import dsr_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// read path
	input wire logic rd_strobe,
	input wire logic rd_clear,
	input wire logic [5:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic rd_hit,
	// events watched
	input wire logic wd_trigger_ok,
	input wire logic [1:0] watchdog_window_phase,
	input wire logic regulator_low_prewarn,
	input wire logic thermal_warning_flag,
	// standby request
	input wire logic force_standby
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// the two mapped reads
	sequence wd_read; rd_strobe && rd_addr == ADDR_WATCHDOG_DIAGNOSIS; endsequence
	sequence sup_read; rd_strobe && rd_addr == ADDR_SUPPLY_THERMAL_DIAGNOSIS; endsequence
	a_answer_next: assert property (rd_strobe |=> rd_valid)
		else $error("read not answered");
	a_no_stray: assert property (!rd_strobe |=> !rd_valid && !rd_hit && rd_data == RESET_BYTE)
		else $error("answer without request");
	a_hit_mapped: assert property (rd_strobe && (rd_addr == ADDR_WATCHDOG_DIAGNOSIS ||
		rd_addr == ADDR_SUPPLY_THERMAL_DIAGNOSIS) |=> rd_hit)
		else $error("mapped address missed");
	a_unmapped_zero: assert property (rd_strobe && rd_addr != ADDR_WATCHDOG_DIAGNOSIS &&
		rd_addr != ADDR_SUPPLY_THERMAL_DIAGNOSIS |=> !rd_hit && rd_data == RESET_BYTE)
		else $error("unmapped address answered");
	a_phase_shown: assert property (wd_read |=> rd_data[1:0] == $past(watchdog_window_phase, 2))
		else $error("window phase wrong");
	a_trigger_zero: assert property (wd_trigger_ok ##1 wd_read |=> rd_data[7:4] == 4'h0)
		else $error("count not zeroed by trigger");
	a_limit_standby: assert property (wd_read ##1 rd_data[7:4] == WD_MISS_LIMIT |->
		force_standby || $past(force_standby))
		else $error("no standby at miss limit");
	a_prewarn_held: assert property (regulator_low_prewarn ##1 sup_read |=> rd_data[7])
		else $error("prewarn lost");
	a_warn_survives: assert property (rd_strobe && rd_clear && thermal_warning_flag &&
		rd_addr == ADDR_SUPPLY_THERMAL_DIAGNOSIS ##1 sup_read |=> rd_data[0])
		else $error("event lost in clear");
endmodule : dsr_diag_regs_sva
bind dsr_diag_regs dsr_diag_regs_sva dsr_diag_regs_sva_i (.*);

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	import dsr_pkg::*;
	// ev: ok, miss, prewarn, restart, thermal_shutdown_level2, thermal_shutdown_level1, warn, short from bit 0 up
	logic mclk = 0, rstn = 0, lo = 0, rnd = 0, fs;
	logic [7:0] ev = 8'h00;
	logic [1:0] ph = 2'h0;
	logic rd_strobe, rd_clear, rd_valid, rd_hit;
	logic [5:0] rd_addr;
	logic [7:0] rd_data, w, s;
	logic [9:0] e1;
	int fail_count = 0, n_compared = 0, run, x, y, seed = 32'h7b43_6310;
	dsr_host dsr_host_i (.mclk, .rd_strobe, .rd_clear, .rd_addr);
	dsr_diag_regs dsr_diag_regs_i (.mclk, .rstn, .rd_strobe, .rd_clear, .rd_addr, .rd_data,
		.rd_valid, .rd_hit, .wd_trigger_ok(ev[0]), .wd_trigger_missed(ev[1]),
		.watchdog_window_phase(ph), .regulator_low_prewarn(ev[2]),
		.main_regulator_output_below_2v(lo), .thermal_shutdown_level2_restart_event(ev[3]),
		.thermal_shutdown_level2(ev[4]), .thermal_shutdown_level1(ev[5]),
		.thermal_warning_flag(ev[6]), .short_at_startup(ev[7]), .force_standby(fs));
	initial forever #25 mclk = ~mclk;
	task chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task results;
		if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	// reference: answer is the state before the edge, then clears, then events win
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{w, s, e1} = 26'h000_0000;
			run = 0;
		end else begin
			e1 = {rd_strobe, 9'h000};
			if (rd_strobe && rd_addr == ADDR_WATCHDOG_DIAGNOSIS) e1 = {2'b11, w};
			if (rd_strobe && rd_addr == ADDR_SUPPLY_THERMAL_DIAGNOSIS) e1 = {2'b11, s};
			if (rd_strobe && rd_clear && e1[9:8] == 2'b11) begin
				if (rd_addr[0]) w[3:2] = 2'b00;
				else s = 8'h00;
			end
			w[1:0] = ph;
			if (ev[0]) w[7:4] = 4'h0;
			else if (ev[1] && w[7:4] != WD_MISS_LIMIT) begin
				w[7:4] = w[7:4] + 4'h1;
				w[3] = w[3] | (w[7:4] == WD_MISS_LIMIT);
			end
			if (ev[3] && s[6:4] != RESTART_LIMIT) begin
				s[6:4] = s[6:4] + 3'h1;
				w[2] = w[2] | (s[6:4] == RESTART_LIMIT);
			end
			w[2] = w[2] | ev[7];
			s = s | {ev[2], 4'h0, ev[4], ev[5], ev[6]};
			run = lo ? run + 1 : 0;
			s[3] = s[3] | (run > COLLAPSE_CYCLES);
		end
	end
	always @(negedge mclk) if (rstn) chk({rd_valid, rd_hit, rd_data}, e1);
	always @(negedge mclk) if (rstn) chk({9'h000, fs}, {9'h000, (w[7:4] == WD_MISS_LIMIT) ||
		(s[6:4] == RESTART_LIMIT) || w[2]});
	// random events: misses frequent, good triggers rare
	always @(posedge mclk) begin
		#1;
		if (rnd) begin
			x = $random(seed);
			y = $random(seed);
			ev = (x[7:0] & x[15:8] & y[7:0] & y[15:8] & (y[23:16] | 8'hfe)) | {6'h00, x[25], 1'b0};
			ph = {x[26] & x[27], x[27]};
		end
	end
	initial begin
		repeat (8) @(posedge mclk);
		#1 rstn = 1;
		rnd = 1;
		// soak: random reads, clears and unmapped addresses
		repeat (600) begin
			@(posedge mclk);
			#1 x = $random(seed);
			if (x[1:0] == 2'b00) dsr_host_i.rd(x[4] ? 6'(x >> 8) : (x[5] ?
				ADDR_WATCHDOG_DIAGNOSIS : ADDR_SUPPLY_THERMAL_DIAGNOSIS), x[6], 1'b1);
		end
		rnd = 0;
		@(posedge mclk);
		#1 ev = 8'h00;
		// restart count to its limit; then both bytes read with clear
		dsr_host_i.rd(ADDR_SUPPLY_THERMAL_DIAGNOSIS, 1'b1, 1'b1);
		repeat (7) begin
			ev[3] = 1'b1;
			@(posedge mclk);
			#1 ev[3] = 1'b0;
		end
		dsr_host_i.rd(ADDR_SUPPLY_THERMAL_DIAGNOSIS, 1'b1, 1'b0);
		dsr_host_i.rd(ADDR_WATCHDOG_DIAGNOSIS, 1'b1, 1'b1);
		// collapse filter: a run of exactly the filter time, then a longer one
		for (int n = 40; n <= 45; n += 5) begin
			lo = 1;
			repeat (n) @(posedge mclk);
			#1 lo = 0;
			repeat (4) @(posedge mclk);
			#1 dsr_host_i.rd(ADDR_SUPPLY_THERMAL_DIAGNOSIS, 1'b1, 1'b1);
		end
		// event landing on the clearing edge must survive
		ev[6] = 1'b1;
		dsr_host_i.rd(ADDR_SUPPLY_THERMAL_DIAGNOSIS, 1'b1, 1'b0);
		ev[6] = 1'b0;
		dsr_host_i.rd(ADDR_SUPPLY_THERMAL_DIAGNOSIS, 1'b0, 1'b1);
		repeat (3) @(posedge mclk);
		results();
	end
	// watchdog: the run needs under a thousand cycles
	initial begin
		#(2000 * 50);
		fail_count++;
		results();
	end
endmodule : tb
